// ===== core/alti_defs.vh
`ifndef ALTI_DEFS_VH
`define ALTI_DEFS_VH

// Bus address: upper six bits fixed, seventh bit is the inverted chip select
`define ALTI_ADDR_HI 6'h3b

// Command bytes and fields
`define ALTI_CMD_RESET 8'h1e
`define ALTI_CMD_RESULT_READ 8'h00
`define ALTI_CMD_MEMORY_READ_FLAG 7
`define ALTI_CMD_CONVERSION_SELECT_FLAG 6
`define ALTI_CMD_TYPE_BIT 4
`define ALTI_CMD_FIELD_MSB 3
`define ALTI_CMD_FIELD_LSB 1
`define ALTI_CMD_STOP_BIT 0
`define ALTI_CMD_CONV_HI 3'h2
`define ALTI_CMD_CALIBRATION_MEMORY_HI 4'ha
`define ALTI_OSR_MAX 3'h4

// Calibration memory map (word index)
`define ALTI_CALIBRATION_MEMORY_FACTORY_SETUP_WORD 3'h0
`define ALTI_CALIBRATION_MEMORY_CALIB_WORD_1 3'h1
`define ALTI_CALIBRATION_MEMORY_CALIB_WORD_2 3'h2
`define ALTI_CALIBRATION_MEMORY_CALIB_WORD_3 3'h3
`define ALTI_CALIBRATION_MEMORY_CALIB_WORD_4 3'h4
`define ALTI_CALIBRATION_MEMORY_WORDS 8
`define ALTI_CALIBRATION_MEMORY_WORD_W 16
`define ALTI_CALIBRATION_MEMORY_CRC_WORD 3'h7
`define ALTI_CALIBRATION_MEMORY_CRC_LSB 0
`define ALTI_CALIBRATION_MEMORY_CRC_W 4
`define ALTI_CALIBRATION_MEMORY_RESET 16'h0000

// Read frame lengths in bytes
`define ALTI_RESULT_BYTES 2'h3
`define ALTI_CALIBRATION_MEMORY_BYTES 2'h2
`define ALTI_RESULT_RESET 24'h000000

`endif

// ===== core/alti_calibration_memory.v
`timescale 1ns/100ps
`include "alti_defs.vh"

module alti_calibration_memory #(
    parameter [127:0] CONTENTS = 128'h0
) (
    input wire clk,
    input wire arst_n,
    input wire load,
    input wire [2:0] addr,
    output reg [15:0] rd_data_q
);

    wire [127:0] flat;

    genvar i;
    generate
        for (i = 0; i < `ALTI_CALIBRATION_MEMORY_WORDS; i = i + 1) begin : g_word
            reg [15:0] word_q;
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    word_q <= `ALTI_CALIBRATION_MEMORY_RESET;
                end else if (load) begin
                    word_q <= CONTENTS[i*16 +: 16];
                end
            end
            assign flat[i*16 +: 16] = word_q;
        end
    endgenerate

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_q <= `ALTI_CALIBRATION_MEMORY_RESET;
        end else begin
            rd_data_q <= flat[addr*16 +: 16];
        end
    end

endmodule

// ===== core/alti_conv.v
`timescale 1ns/100ps

module alti_conv #(
    parameter BASE_CYCLES = 16384
) (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire abort,
    input wire [2:0] oversample_setting,
    output reg busy_q,
    output reg done_q
);

    reg [23:0] cnt_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 24'h000000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
                cnt_q <= 24'h000000;
            end else if (start && !busy_q) begin
                // Each oversampling step doubles the conversion time
                busy_q <= 1'b1;
                cnt_q <= (BASE_CYCLES[23:0] << oversample_setting) - 24'h000001;
            end else if (busy_q) begin
                if (cnt_q == 24'h000000) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 24'h000001;
                end
            end
        end
    end

endmodule

// ===== core/alti_i2c.v
// Summary of operation
// [R1] Frames open with a host start and close with a host stop.
// [R2] Answer address 111011C, C the inverted chip select; last bit is read/write.
// [R3] Reset command frame is accepted at any moment, aborting any activity.
// [R4] A stuck data line after failed power-up needs a power cycle by the host.
// [R5] A conversion command starts the conversion; busy until it finishes.
// [R6] Highest oversampling pressure conversion is one command byte in a write frame.
// [R7] Result read shifts out 24 bits, most significant byte first.
// [R8] After each returned byte wait for the host acknowledge bit.
// [R9] Host acknowledges all bytes but the last, then not-acknowledge and stop.
// [R10] Memory read: write frame with command, then read frame returning the word.
// [R11] Memory read command is 8 bits, answer is 16 bits MSB first.
// [R12] Calibration memory holds eight 16-bit words, chosen by a 3-bit field.
// [R13] Word 0 factory setup, words 1-6 coefficients, word 7 serial and check code.
// [R14] Coefficient words return as 16-bit unsigned values.
// [R15] Address field 011 returns the third coefficient word.
// [R16] Calibration memory carries a 4-bit check code for host validation.
// [R17] Host reads calibration memory once after every reset.
// [R18] Conversion byte: type bit plus 3-bit oversampling; 0x40-0x48, 0x50-0x58.
// [R19] Reset is 0x1e; memory reads 0xa0-0xae with address in bits 3 to 1.
// [R20] Reset reloads calibration memory into the internal register.
// [R21] Read with no fresh result returns zero; read during conversion corrupts it.
// [R22] Address bytes not matching the own address are not acknowledged.
`timescale 1ns/100ps
`include "alti_defs.vh"

module alti_i2c #(
    parameter CONV_BASE_CYCLES = 16384,
    parameter [127:0] CALIBRATION_MEMORY_CONTENTS = 128'h0003_0000_0000_0000_0000_0000_0000_0000
) (
    input wire clk,
    input wire arst_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_q,
    input wire chip_select_pin,
    input wire [23:0] raw_pressure_result,
    input wire [23:0] raw_temperature_result,
    output wire conv_busy
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_AACK = 3'h2;
    localparam [2:0] S_CMD = 3'h3;
    localparam [2:0] S_CACK = 3'h4;
    localparam [2:0] S_TX = 3'h5;
    localparam [2:0] S_TACK = 3'h6;

    reg scl_s1_q, scl_s2_q, scl_prev_q;
    reg sda_s1_q, sda_s2_q, sda_prev_q;
    reg cs_s1_q, cs_s2_q;

    reg [2:0] state_q;
    reg [2:0] cnt_q;
    reg [7:0] rx_q;
    reg rw_q;
    reg ack_ph_q;
    reg more_q;
    reg [1:0] left_q;
    reg [23:0] tx_q;
    reg cmd_stb_q;
    reg [7:0] cmd_q;
    reg rd_stb_q;

    reg [23:0] result_q;
    reg corrupt_q;
    reg conv_type_q;
    reg calibration_memory_mode_q;
    reg [2:0] calibration_memory_addr_q;
    reg calibration_memory_load_q;
    reg conv_start_q;
    reg [2:0] conv_osr_q;
    reg conv_abort_q;

    wire [15:0] calibration_memory_word;
    wire conv_done;
    wire [7:0] rx_byte;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire addr_match;
    wire is_conv;
    wire is_calibration_memory;
    wire [23:0] frame;
    wire [1:0] frame_bytes;

    assign sda_out = 1'b0;
    assign scl_rise = scl_s2_q && !scl_prev_q;
    assign scl_fall = !scl_s2_q && scl_prev_q;
    assign start_cond = scl_s2_q && scl_prev_q && !sda_s2_q && sda_prev_q; // see [R1]
    assign stop_cond = scl_s2_q && scl_prev_q && sda_s2_q && !sda_prev_q; // see [R1]
    assign rx_byte = {rx_q[6:0], sda_s2_q};
    assign addr_match = (rx_byte[7:1] == {`ALTI_ADDR_HI, ~cs_s2_q}); // see [R2] [R22]

    // Command decode: stop bit must be clear, field limited to legal values
    assign is_conv = (cmd_q[7:5] == `ALTI_CMD_CONV_HI) && !cmd_q[`ALTI_CMD_STOP_BIT]
        && (cmd_q[`ALTI_CMD_FIELD_MSB:`ALTI_CMD_FIELD_LSB] <= `ALTI_OSR_MAX); // see [R18] [R6]
    assign is_calibration_memory = (cmd_q[7:4] == `ALTI_CMD_CALIBRATION_MEMORY_HI) && !cmd_q[`ALTI_CMD_STOP_BIT]; // see [R19]

    // A result read during conversion or without a fresh result yields zero
    assign frame = calibration_memory_mode_q ? {calibration_memory_word, 8'h00} :
        (conv_busy ? `ALTI_RESULT_RESET : result_q); // see [R21] [R11]
    assign frame_bytes = calibration_memory_mode_q ? `ALTI_CALIBRATION_MEMORY_BYTES : `ALTI_RESULT_BYTES; // see [R7]

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_prev_q <= 1'b1;
            cs_s1_q <= 1'b0;
            cs_s2_q <= 1'b0;
        end else begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_prev_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_prev_q <= sda_s2_q;
            cs_s1_q <= chip_select_pin;
            cs_s2_q <= cs_s1_q;
        end
    end

    // Bus engine: sample on clock rise, change the data line on clock fall
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            cnt_q <= 3'h0;
            rx_q <= 8'h00;
            rw_q <= 1'b0;
            ack_ph_q <= 1'b0;
            more_q <= 1'b0;
            left_q <= 2'h0;
            tx_q <= 24'h000000;
            sda_oe_q <= 1'b0;
            cmd_stb_q <= 1'b0;
            cmd_q <= 8'h00;
            rd_stb_q <= 1'b0;
        end else begin
            cmd_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            if (stop_cond) begin
                state_q <= S_IDLE; // see [R1]
                sda_oe_q <= 1'b0;
            end else if (start_cond) begin
                state_q <= S_ADDR; // see [R1] [R3]
                cnt_q <= 3'h0;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    S_ADDR: begin
                        rx_q <= rx_byte;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            rw_q <= sda_s2_q;
                            ack_ph_q <= 1'b0;
                            state_q <= addr_match ? S_AACK : S_IDLE; // see [R22]
                        end
                    end
                    S_CMD: begin
                        rx_q <= rx_byte;
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            cmd_q <= rx_byte;
                            cmd_stb_q <= 1'b1;
                            ack_ph_q <= 1'b0;
                            state_q <= S_CACK;
                        end
                    end
                    S_TX: begin
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            state_q <= S_TACK; // see [R8]
                        end
                    end
                    S_TACK: begin
                        // Host not-acknowledge ends the read
                        if (!sda_s2_q && left_q != 2'h0) begin
                            more_q <= 1'b1; // see [R8] [R9]
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    S_AACK: begin
                        if (!ack_ph_q) begin
                            ack_ph_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                        end else if (rw_q) begin
                            tx_q <= frame; // see [R7] [R10]
                            sda_oe_q <= ~frame[23];
                            left_q <= frame_bytes - 2'h1;
                            rd_stb_q <= 1'b1;
                            cnt_q <= 3'h0;
                            state_q <= S_TX;
                        end else begin
                            sda_oe_q <= 1'b0;
                            cnt_q <= 3'h0;
                            state_q <= S_CMD;
                        end
                    end
                    S_CACK: begin
                        if (!ack_ph_q) begin
                            ack_ph_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                        end else begin
                            // Only one command byte per frame; the rest is ignored
                            sda_oe_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                    S_TX: begin
                        sda_oe_q <= ~tx_q[22];
                        tx_q <= {tx_q[22:0], 1'b0};
                    end
                    S_TACK: begin
                        if (more_q) begin
                            more_q <= 1'b0;
                            left_q <= left_q - 2'h1;
                            sda_oe_q <= ~tx_q[22];
                            tx_q <= {tx_q[22:0], 1'b0};
                            cnt_q <= 3'h0;
                            state_q <= S_TX;
                        end else begin
                            sda_oe_q <= 1'b0; // see [R8]
                        end
                    end
                    default: begin
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Command execution and conversion result keeping
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q <= `ALTI_RESULT_RESET;
            corrupt_q <= 1'b0;
            conv_type_q <= 1'b0;
            calibration_memory_mode_q <= 1'b0;
            calibration_memory_addr_q <= 3'h0;
            calibration_memory_load_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_osr_q <= 3'h0;
            conv_abort_q <= 1'b0;
        end else begin
            calibration_memory_load_q <= 1'b0;
            conv_start_q <= 1'b0;
            conv_abort_q <= 1'b0;
            if (cmd_stb_q && cmd_q == `ALTI_CMD_RESET) begin
                calibration_memory_load_q <= 1'b1; // see [R3] [R20]
                conv_abort_q <= 1'b1;
                corrupt_q <= 1'b0;
                calibration_memory_mode_q <= 1'b0;
                result_q <= `ALTI_RESULT_RESET;
            end else begin
                // A finishing conversion is kept even if a command other than reset lands in the same cycle
                if (conv_done) begin
                    result_q <= {24{corrupt_q}} ^
                        (conv_type_q ? raw_temperature_result : raw_pressure_result);
                    corrupt_q <= 1'b0;
                end else if (rd_stb_q && !calibration_memory_mode_q) begin
                    // Result is handed out once; a repeated read sees zero
                    result_q <= `ALTI_RESULT_RESET; // see [R21]
                    if (conv_busy) begin
                        corrupt_q <= 1'b1; // see [R21]
                    end
                end
                if (cmd_stb_q) begin
                    if (is_conv) begin
                        // A second start mid-conversion only spoils the running one
                        if (conv_busy) begin
                            corrupt_q <= 1'b1; // see [R21]
                        end else begin
                            conv_start_q <= 1'b1; // see [R5] [R6]
                            conv_osr_q <= cmd_q[`ALTI_CMD_FIELD_MSB:`ALTI_CMD_FIELD_LSB];
                            conv_type_q <= cmd_q[`ALTI_CMD_TYPE_BIT];
                            corrupt_q <= 1'b0;
                        end
                        calibration_memory_mode_q <= 1'b0;
                    end else if (is_calibration_memory) begin
                        calibration_memory_mode_q <= 1'b1; // see [R10] [R12]
                        calibration_memory_addr_q <= cmd_q[`ALTI_CMD_FIELD_MSB:`ALTI_CMD_FIELD_LSB]; // see [R15]
                    end else if (cmd_q == `ALTI_CMD_RESULT_READ) begin
                        calibration_memory_mode_q <= 1'b0;
                    end
                end
            end
        end
    end

    alti_calibration_memory #(
        .CONTENTS(CALIBRATION_MEMORY_CONTENTS)
    ) u_calibration_memory (
        .clk(clk),
        .arst_n(arst_n),
        .load(calibration_memory_load_q),
        .addr(calibration_memory_addr_q),
        .rd_data_q(calibration_memory_word)
    ); // see [R12] [R13] [R14] [R16]

    alti_conv #(
        .BASE_CYCLES(CONV_BASE_CYCLES)
    ) u_conv (
        .clk(clk),
        .arst_n(arst_n),
        .start(conv_start_q),
        .abort(conv_abort_q),
        .oversample_setting(conv_osr_q),
        .busy_q(conv_busy),
        .done_q(conv_done)
    ); // see [R5]

endmodule

// ===== verif/alti_i2c_properties.sv
`timescale 1ns/100ps
module alti_i2c_props #(
    parameter CONV_BASE_CYCLES = 16
) (
    input wire clk,
    input wire arst_n,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_q,
    input wire chip_select_pin,
    input wire [23:0] raw_pressure_result,
    input wire [23:0] raw_temperature_result,
    input wire conv_busy
);
    localparam int BUSY_MIN = CONV_BASE_CYCLES;
    localparam int BUSY_MAX = (CONV_BASE_CYCLES << 4) + 8;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    drive_is_low_a: assert property (sda_oe_q |-> sda_out == 1'b0)
        else $error("data line driven high");
    oe_scl_low_a: assert property ($changed(sda_oe_q) |-> !scl_in && !$past(scl_in, 2))
        else $error("data line moved while bus clock high");
    start_free_a: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> !$past(sda_oe_q))
        else $error("device held data line at a start");
    oe_bounded_a: assert property ($rose(sda_oe_q) |-> ##[1:100] !sda_oe_q)
        else $error("no release for host acknowledge");
    busy_min_a: assert property ($rose(conv_busy) |-> conv_busy [*8] ##1 conv_busy [*8])
        else $error("conversion ended too early");
    busy_max_a: assert property ($rose(conv_busy) |-> ##[BUSY_MIN:BUSY_MAX] !conv_busy)
        else $error("conversion did not end in time");
    busy_then_ack_a: assert property ($rose(conv_busy) |-> !sda_oe_q ##[1:12] sda_oe_q)
        else $error("conversion not tied to command byte");
    reset_quiet_a: assert property (!$past(arst_n) |-> !conv_busy && !sda_oe_q)
        else $error("outputs active after reset");
    cover property ($rose(conv_busy));
    cover property ($rose(sda_oe_q));
    cover property ($fell(conv_busy) ##[1:400] $rose(sda_oe_q));
endmodule

bind alti_i2c alti_i2c_props #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) u_props (
    .clk(clk),
    .arst_n(arst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_q(sda_oe_q),
    .chip_select_pin(chip_select_pin),
    .raw_pressure_result(raw_pressure_result),
    .raw_temperature_result(raw_temperature_result),
    .conv_busy(conv_busy)
);

// ===== verif/alti_host_model.sv
`timescale 1ns/100ps
module alti_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    // Bus clock stands high between frames; the host never holds the line idle low
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        ticks(5);
        sda_oe = 1'b1;
        ticks(5);
        scl = 1'b0;
    endtask
    task automatic stop();
        ticks(3);
        sda_oe = 1'b1;
        ticks(2);
        scl = 1'b1;
        ticks(5);
        sda_oe = 1'b0;
        ticks(5);
    endtask
    // Data changes mid low phase so it is settled well before the clock rises
    task automatic bit_io(input logic b, output logic got);
        ticks(3);
        sda_oe = ~b;
        ticks(2);
        scl = 1'b1;
        ticks(3);
        got = sda;
        ticks(2);
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(d[i], g);
        bit_io(1'b1, ack);
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, g);
    endtask
endmodule

// ===== verif/altimeter_i2c_command_port_tb.sv
`timescale 1ns/100ps
module altimeter_i2c_command_port_tb;
    localparam int BASE = 16;
    localparam logic [127:0] CALIBRATION_MEMORY_C = {16'h7b2c, 16'h6f06, 16'h5e05, 16'h4d04,
        16'h3c03, 16'h2b02, 16'h1a01, 16'h0f00};
    localparam logic [23:0] PRESS = 24'ha1b2c3;
    localparam logic [23:0] TEMP = 24'h5d6e7f;
    typedef struct packed {logic [7:0] cmd; logic [23:0] exp;} alti_row_t;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cs = 1'b1;
    logic [23:0] press = PRESS;
    logic [23:0] temp = TEMP;
    wire scl;
    wire host_oe;
    wire sda_out;
    wire sda_oe_q;
    wire conv_busy;
    wire sda = host_oe ? 1'b0 : (sda_oe_q ? sda_out : 1'b1);
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    alti_row_t rows [18];
    always #4 clk = ~clk;
    alti_i2c #(.CONV_BASE_CYCLES(BASE), .CALIBRATION_MEMORY_CONTENTS(CALIBRATION_MEMORY_C)) uut (
        .clk(clk),
        .arst_n(arst_n),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe_q(sda_oe_q),
        .chip_select_pin(cs),
        .raw_pressure_result(press),
        .raw_temperature_result(temp),
        .conv_busy(conv_busy)
    );
    alti_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    function automatic logic [7:0] addr(input logic rw);
        return {6'h3b, ~cs, rw};
    endfunction
    task automatic cmd_frame(input logic [7:0] cmd);
        logic a1;
        logic a2;
        host.start();
        host.wbyte(addr(1'b0), a1);
        host.wbyte(cmd, a2);
        host.stop();
        check({22'h0, a1, a2}, 24'h0, "command acks");
    endtask
    task automatic read_frame(input int n, output logic [23:0] d);
        logic a;
        logic [7:0] b;
        d = 24'h0;
        host.start();
        host.wbyte(addr(1'b1), a);
        check({23'h0, a}, 24'h0, "read address ack");
        for (int i = 0; i < n; i++) begin
            host.rbyte(i == n - 1, b);
            d = {d[15:0], b};
        end
        host.stop();
    endtask
    task automatic expect_read(input logic [7:0] cmd, input int n, input logic [23:0] exp);
        logic [23:0] d;
        cmd_frame(cmd);
        read_frame(n, d);
        check(d, exp, "read data");
    endtask
    task automatic wait_busy(input logic lvl);
        int k = 0;
        while (conv_busy !== lvl && k < 600) begin
            @(negedge clk);
            k++;
        end
        check({23'h0, conv_busy}, {23'h0, lvl}, "busy level");
    endtask
    initial begin
        logic [23:0] d;
        logic a;
        for (int t = 0; t < 2; t++) begin
            for (int o = 0; o < 5; o++) begin
                rows[t * 5 + o] = '{{3'b010, t[0], o[2:0], 1'b0}, t[0] ? TEMP : PRESS};
            end
        end
        for (int w = 0; w < 8; w++) begin
            rows[10 + w] = '{{4'ha, w[2:0], 1'b0}, {8'h00, CALIBRATION_MEMORY_C[16 * w +: 16]}};
        end
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        cmd_frame(8'h1e);
        for (int i = 0; i < 18; i++) begin
            if (rows[i].cmd[7]) begin
                expect_read(rows[i].cmd, 2, rows[i].exp);
            end else begin
                cmd_frame(rows[i].cmd);
                wait_busy(1'b0);
                expect_read(8'h00, 3, rows[i].exp);
            end
        end
        $display("test table done");
        expect_read(8'h00, 3, 24'h0);
        $display("test repeated read done");
        // Oversampling field above the top setting must start nothing
        cmd_frame(8'h4a);
        check({23'h0, conv_busy}, 24'h0, "busy after unused code");
        $display("test unused code done");
        cmd_frame(8'h48);
        wait_busy(1'b1);
        read_frame(3, d);
        check(d, 24'h0, "read while busy");
        wait_busy(1'b0);
        expect_read(8'h00, 3, ~PRESS);
        $display("test read during conversion done");
        cmd_frame(8'h48);
        cmd_frame(8'h1e);
        check({23'h0, conv_busy}, 24'h0, "busy after reset command");
        expect_read(8'h00, 3, 24'h0);
        expect_read(8'ha6, 2, {8'h00, CALIBRATION_MEMORY_C[63:48]});
        $display("test reset command done");
        cs = 1'b0;
        for (int j = 0; j < 2; j++) begin
            host.start();
            host.wbyte(j ? 8'he6 : 8'hec, a);
            host.stop();
            check({23'h0, a}, 24'h1, "foreign address");
        end
        expect_read(8'ha6, 2, {8'h00, CALIBRATION_MEMORY_C[63:48]});
        $display("test address done");
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        check({22'h0, sda_oe_q, conv_busy}, 24'h0, "outputs in reset");
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        expect_read(8'ha6, 2, 24'h0);
        cmd_frame(8'h1e);
        expect_read(8'ha6, 2, {8'h00, CALIBRATION_MEMORY_C[63:48]});
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
